//--- core/slm_pkg.sv
package slm_pkg;
    // register indices; byte address is four times the index
    localparam logic [10:0] IDX_STRAY_CHAR = 11'h46F;
    localparam logic [10:0] IDX_CODE_GROUP = 11'h470;
    localparam logic [10:0] IDX_FRAME_LOCK = 11'h471;
    localparam logic [10:0] IDX_CHECKSUM = 11'h472;
    localparam logic [10:0] IDX_ALIGNMENT = 11'h473;
    localparam logic [10:0] IDX_FRAME_SIZE = 11'h476;
    localparam logic [10:0] IDX_IRQ_VECTOR = 11'h47A;
    localparam logic [10:0] IDX_LIMIT = 11'h47C;
    localparam logic [10:0] IDX_IRQ_MASK = 11'h480;

    localparam int ADR_W = 11;
    localparam int ADR_LSB = 2;
    localparam int REG_W = 8;
    localparam int BUS_W = 32;
    localparam int SEL_W = 4;
    localparam int LANE_ADR_W = 3;

    // command register fields
    localparam int CMD_CLR_IRQ = 7;
    localparam int CMD_HALT = 6;
    localparam int CMD_ZERO = 5;
    localparam int CMD_LANE_LSB = 0;
    localparam int FLAG_CLR_BIT = 7;

    // interrupt vector layout
    localparam int VEC_CODE_GROUP = 0;
    localparam int VEC_FRAME_LOCK = 1;
    localparam int VEC_CHECKSUM = 2;
    localparam int VEC_ALIGNMENT = 3;
    localparam int VEC_STRAY_CHAR = 5;

    localparam logic [7:0] FRAME_SIZE_RST = 8'h01;
    localparam logic [7:0] LIMIT_RST = 8'hFF;
    localparam logic [7:0] REG_ZERO = 8'h00;
endpackage : slm_pkg

//--- core/slm_reg_if.sv
`timescale 1ns/1ns
`default_nettype none
interface slm_reg_if;
    logic wr_stb;
    logic [slm_pkg::ADR_W-1:0] idx;
    logic [slm_pkg::REG_W-1:0] wdata;
    logic [slm_pkg::REG_W-1:0] rdata;
    modport bus (output wr_stb, output idx, output wdata, input rdata);
    modport regs (input wr_stb, input idx, input wdata, output rdata);
endinterface : slm_reg_if
`default_nettype wire

//--- core/slm_wb_slave.sv
`timescale 1ns/1ns
`default_nettype none
module slm_wb_slave (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [slm_pkg::ADR_W+slm_pkg::ADR_LSB-1:0] wb_adr_i,
    input wire logic [slm_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [slm_pkg::BUS_W-1:0] wb_dat_i,
    output logic [slm_pkg::BUS_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // register side
    slm_reg_if.bus rg
);
    import slm_pkg::*;

    logic ack_q;
    logic [BUS_W-1:0] dat_q;
    wire req = wb_cyc_i & wb_stb_i & ~ack_q;

    // only lane 0 carries data, so a write without it is dropped
    assign rg.wr_stb = req & wb_we_i & wb_sel_i[0];
    assign rg.idx = wb_adr_i[ADR_W+ADR_LSB-1:ADR_LSB];
    assign rg.wdata = wb_dat_i[REG_W-1:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= req;
            dat_q <= {{(BUS_W-REG_W){1'b0}}, rg.rdata};
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
endmodule : slm_wb_slave
`default_nettype wire

//--- core/slm_err_counter.sv
`timescale 1ns/1ns
`default_nettype none
module slm_err_counter #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // events and commands
    input wire logic err_i,
    input wire logic halt_i,
    input wire logic zero_i,
    input wire logic [CNT_W-1:0] limit_i,
    // state
    output logic over_o
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic run_q;
    wire full = &cnt_q;

    // saturates so a flood of errors never wraps back below the limit
    assign cnt_d = zero_i ? '0 :
                   (err_i & run_q & ~halt_i & ~full) ? cnt_q + 1'b1 : cnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            run_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            run_q <= halt_i ? 1'b0 : (zero_i ? 1'b1 : run_q);
        end
    end

    assign over_o = (cnt_q >= limit_i);
endmodule : slm_err_counter
`default_nettype wire

//--- core/slm_top.sv
// Behaviour
// - a lane's stray-character status bit sets when its count reaches the limit
// - command bit 7 clears the stray-character interrupt of the named lane
// - command bit 6 stops the named lane's stray-character counter
// - command bit 5 zeroes the named lane's stray-character counter
// - the lane number in bits 2..0 selects where bits 7..5 act
// - one code-group lock bit per lane, 0 lost, 1 achieved
// - bit 7 write clears code-group interrupt, held at vector bit 0
// - any code-group lock loss raises the sync request to the transmitter
// - live frame lock per lane; bit 7 write clears its interrupt
// - frame lock loss starts a new link synchronisation by itself
// - per lane, 1 when the last checksum matched, else 0
// - bit 7 write clears checksum interrupt, held at vector bit 2
// - one alignment lock bit per lane; bit 7 clears vector bit 3
// - alignment lock loss is also shown on the sync request outputs
// - each lane's count is compared with the common limit register
`timescale 1ns/1ns
`default_nettype none
module slm_top #(
    parameter int LANES = 8,
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [slm_pkg::ADR_W+slm_pkg::ADR_LSB-1:0] wb_adr_i,
    input wire logic [slm_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [slm_pkg::BUS_W-1:0] wb_dat_i,
    output logic [slm_pkg::BUS_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // lane status from the deserialiser
    input wire logic [LANES-1:0] stray_ctrl_char_error_i,
    input wire logic [LANES-1:0] code_group_lock_i,
    input wire logic [LANES-1:0] frame_lock_i,
    input wire logic [LANES-1:0] checksum_match_i,
    input wire logic [LANES-1:0] alignment_sequence_lock_i,
    // link control
    output logic sync_request_out_a_o,
    output logic sync_request_out_b_o,
    output logic resync_start_o,
    output logic [slm_pkg::REG_W-1:0] frame_size_o,
    // interrupt
    output logic irq_o
);
    import slm_pkg::*;

    function automatic logic [LANES-1:0] lane_hit(
        input logic [LANE_ADR_W-1:0] lane,
        input logic go
    );
        lane_hit = '0;
        lane_hit[lane] = go;
    endfunction

    slm_reg_if rg ();

    slm_wb_slave u_bus (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .rg(rg)
    );

    // write decode
    wire wr_cmd = rg.wr_stb & (rg.idx == IDX_STRAY_CHAR);
    wire wr_cg = rg.wr_stb & (rg.idx == IDX_CODE_GROUP);
    wire wr_fl = rg.wr_stb & (rg.idx == IDX_FRAME_LOCK);
    wire wr_ck = rg.wr_stb & (rg.idx == IDX_CHECKSUM);
    wire wr_al = rg.wr_stb & (rg.idx == IDX_ALIGNMENT);
    wire wr_fs = rg.wr_stb & (rg.idx == IDX_FRAME_SIZE);
    wire wr_vec = rg.wr_stb & (rg.idx == IDX_IRQ_VECTOR);
    wire wr_lim = rg.wr_stb & (rg.idx == IDX_LIMIT);
    wire wr_msk = rg.wr_stb & (rg.idx == IDX_IRQ_MASK);

    // command pulses live only for the write cycle itself
    wire [LANE_ADR_W-1:0] cmd_lane =
        rg.wdata[CMD_LANE_LSB +: LANE_ADR_W];
    wire [LANES-1:0] clr_irq_hit =
        lane_hit(cmd_lane, wr_cmd & rg.wdata[CMD_CLR_IRQ]);
    wire [LANES-1:0] halt_hit =
        lane_hit(cmd_lane, wr_cmd & rg.wdata[CMD_HALT]);
    wire [LANES-1:0] zero_hit =
        lane_hit(cmd_lane, wr_cmd & rg.wdata[CMD_ZERO]);

    logic [REG_W-1:0] limit_q;
    logic [REG_W-1:0] frame_size_q;
    logic [REG_W-1:0] mask_q;
    logic [REG_W-1:0] vec_q;
    logic [LANES-1:0] over;
    logic [LANES-1:0] over_q;
    logic [LANES-1:0] stray_irq_q;
    logic [LANES-1:0] cg_q;
    logic [LANES-1:0] fl_q;
    logic [LANES-1:0] ck_q;
    logic [LANES-1:0] al_q;
    logic sync_a_q;
    logic sync_b_q;
    logic resync_q;
    logic irq_q;

    // per-lane stray character counters
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        slm_err_counter #(
            .CNT_W(CNT_W)
        ) u_cnt (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .err_i(stray_ctrl_char_error_i[g]),
            .halt_i(halt_hit[g]),
            .zero_i(zero_hit[g]),
            .limit_i(limit_q[CNT_W-1:0]),
            .over_o(over[g])
        );
    end

    // loss events: a lock bit that was high and is now low, plus over_rise for a lane newly over the limit
    wire [LANES-1:0] cg_loss = cg_q & ~code_group_lock_i;
    wire [LANES-1:0] fl_loss = fl_q & ~frame_lock_i;
    wire [LANES-1:0] ck_bad = ck_q & ~checksum_match_i;
    wire [LANES-1:0] al_loss = al_q & ~alignment_sequence_lock_i;
    wire [LANES-1:0] over_rise = over & ~over_q;

    // sticky vector: an event in the clearing cycle still lands
    logic [REG_W-1:0] vec_set;
    logic [REG_W-1:0] vec_clr;
    always_comb begin
        vec_set = '0;
        vec_set[VEC_CODE_GROUP] = |cg_loss;
        vec_set[VEC_FRAME_LOCK] = |fl_loss;
        vec_set[VEC_CHECKSUM] = |ck_bad;
        vec_set[VEC_ALIGNMENT] = |al_loss;
        vec_clr = '0;
        if (wr_vec) begin
            vec_clr = rg.wdata;
        end
        vec_clr[VEC_CODE_GROUP] = vec_clr[VEC_CODE_GROUP]
                                | (wr_cg & rg.wdata[FLAG_CLR_BIT]);
        vec_clr[VEC_FRAME_LOCK] = vec_clr[VEC_FRAME_LOCK]
                                | (wr_fl & rg.wdata[FLAG_CLR_BIT]);
        vec_clr[VEC_CHECKSUM] = vec_clr[VEC_CHECKSUM]
                              | (wr_ck & rg.wdata[FLAG_CLR_BIT]);
        vec_clr[VEC_ALIGNMENT] = vec_clr[VEC_ALIGNMENT]
                               | (wr_al & rg.wdata[FLAG_CLR_BIT]);
        vec_clr[VEC_STRAY_CHAR] = 1'b0;
    end

    wire [REG_W-1:0] vec_d = (vec_q & ~vec_clr) | vec_set;
    wire [REG_W-1:0] vec_view = {vec_q[REG_W-1:VEC_STRAY_CHAR+1],
                                 |stray_irq_q,
                                 vec_q[VEC_STRAY_CHAR-1:0]};
    // sync request also covers the lanes being dropped this cycle
    wire sync_need = ~&code_group_lock_i
                   | ~&alignment_sequence_lock_i
                   | (|fl_loss);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            limit_q <= LIMIT_RST;
            frame_size_q <= FRAME_SIZE_RST;
            mask_q <= REG_ZERO;
            vec_q <= REG_ZERO;
            over_q <= '0;
            stray_irq_q <= '0;
            cg_q <= '0;
            fl_q <= '0;
            ck_q <= '0;
            al_q <= '0;
            sync_a_q <= 1'b0;
            sync_b_q <= 1'b0;
            resync_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            if (wr_lim) begin
                limit_q <= rg.wdata;
            end
            if (wr_fs) begin
                frame_size_q <= rg.wdata;
            end
            if (wr_msk) begin
                mask_q <= rg.wdata;
            end
            vec_q <= vec_d;
            over_q <= over;
            stray_irq_q <= (stray_irq_q & ~clr_irq_hit) | over_rise;
            cg_q <= code_group_lock_i;
            fl_q <= frame_lock_i;
            ck_q <= checksum_match_i;
            al_q <= alignment_sequence_lock_i;
            sync_a_q <= sync_need;
            sync_b_q <= sync_need;
            resync_q <= |fl_loss;
            irq_q <= |(vec_view & mask_q);
        end
    end

    // read path; unmapped indices read zero
    wire [LANES-1:0] rd_stray = over;
    wire [LANES-1:0] rd_cg = code_group_lock_i;
    wire [LANES-1:0] rd_fl = frame_lock_i;
    wire [LANES-1:0] rd_ck = checksum_match_i;
    wire [LANES-1:0] rd_al = alignment_sequence_lock_i;
    wire [REG_W-1:0] pad = '0;
    assign rg.rdata =
        (rg.idx == IDX_STRAY_CHAR) ? REG_W'({pad, rd_stray}) :
        (rg.idx == IDX_CODE_GROUP) ? REG_W'({pad, rd_cg}) :
        (rg.idx == IDX_FRAME_LOCK) ? REG_W'({pad, rd_fl}) :
        (rg.idx == IDX_CHECKSUM) ? REG_W'({pad, rd_ck}) :
        (rg.idx == IDX_ALIGNMENT) ? REG_W'({pad, rd_al}) :
        (rg.idx == IDX_FRAME_SIZE) ? frame_size_q :
        (rg.idx == IDX_IRQ_VECTOR) ? vec_view :
        (rg.idx == IDX_LIMIT) ? limit_q :
        (rg.idx == IDX_IRQ_MASK) ? mask_q : REG_ZERO;

    assign sync_request_out_a_o = sync_a_q;
    assign sync_request_out_b_o = sync_b_q;
    assign resync_start_o = resync_q;
    assign frame_size_o = frame_size_q;
    assign irq_o = irq_q;
endmodule : slm_top
`default_nettype wire

//--- bench/slm_checker.sv
`timescale 1ns/1ns
`default_nettype none
module slm_checker #(
    parameter int LANES = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [slm_pkg::BUS_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    // lane status and link control
    input wire logic [LANES-1:0] code_group_lock_i,
    input wire logic [LANES-1:0] frame_lock_i,
    input wire logic sync_request_out_a_o,
    input wire logic sync_request_out_b_o,
    input wire logic resync_start_o,
    input wire logic [slm_pkg::REG_W-1:0] frame_size_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_rst;
        disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_o && !resync_start_o
            && !sync_request_out_a_o
            && frame_size_o == slm_pkg::FRAME_SIZE_RST;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not at reset values");
    property p_answer;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_answer: assert property (p_answer)
        else $error("request not answered next cycle");
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack longer than one cycle");
    property p_quiet;
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("ack without request");
    property p_hi;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
    endproperty
    a_hi: assert property (p_hi)
        else $error("upper read data not zero");
    property p_sync;
        |(~code_group_lock_i) |-> ##[1:2] sync_request_out_a_o;
    endproperty
    a_sync: assert property (p_sync)
        else $error("lock loss without sync request");
    property p_sync_pair;
        sync_request_out_a_o == sync_request_out_b_o;
    endproperty
    a_sync_pair: assert property (p_sync_pair)
        else $error("sync request outputs differ");
    // history guard: the design's loss detect is blind for one edge after reset
    property p_resync;
        !$past(rst_i) && !$past(rst_i, 2)
            && |($past(frame_lock_i) & ~frame_lock_i) |=> resync_start_o;
    endproperty
    a_resync: assert property (p_resync)
        else $error("frame lock loss without resync");
    property p_resync_why;
        resync_start_o |-> |($past(frame_lock_i, 2) & ~$past(frame_lock_i));
    endproperty
    a_resync_why: assert property (p_resync_why)
        else $error("resync without frame lock loss");
    property p_size;
        $changed(frame_size_o) && !$past(rst_i) |-> wb_ack_o && wb_we_i;
    endproperty
    a_size: assert property (p_size)
        else $error("frame size moved without write");
    c_resync: cover property (resync_start_o);
    c_irq: cover property ($rose(irq_o));
    c_sync: cover property ($fell(sync_request_out_a_o));
endmodule // slm_checker
bind slm_top slm_checker #(.LANES(LANES)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .code_group_lock_i(code_group_lock_i),
    .frame_lock_i(frame_lock_i),
    .sync_request_out_a_o(sync_request_out_a_o),
    .sync_request_out_b_o(sync_request_out_b_o),
    .resync_start_o(resync_start_o), .frame_size_o(frame_size_o),
    .irq_o(irq_o));
`default_nettype wire

//--- bench/slm_xmit_model.sv
`timescale 1ns/1ns
`default_nettype none
module slm_xmit_model #(
    parameter int LAT = 2
) (
    // clock
    input wire logic clk_i,
    // bench wishes: align, checksum, frame, code group, errors
    input wire logic [39:0] want_i,
    // lane status toward the receiver
    output logic [39:0] lane_o
);
    // delay line: a slow far end must not be answered on the same edge
    logic [39:0] pipe_q [LAT];
    always_ff @(posedge clk_i) begin
        pipe_q[0] <= want_i;
        for (int i = 1; i < LAT; i++) begin
            pipe_q[i] <= pipe_q[i-1];
        end
    end
    assign lane_o = pipe_q[LAT-1];
endmodule // slm_xmit_model
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import slm_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ack, sync_a, sync_b, resync, irq;
    logic [12:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [7:0] fsize;
    logic [39:0] want, lane;
    logic [7:0] q[$];
    int fail_count = 0;
    int checks_done = 0;
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    slm_xmit_model #(.LAT(2)) i_far (
        .clk_i(clk_i), .want_i(want), .lane_o(lane));
    slm_top i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack),
        .stray_ctrl_char_error_i(lane[7:0]),
        .code_group_lock_i(lane[15:8]), .frame_lock_i(lane[23:16]),
        .checksum_match_i(lane[31:24]),
        .alignment_sequence_lock_i(lane[39:32]),
        .sync_request_out_a_o(sync_a), .sync_request_out_b_o(sync_b),
        .resync_start_o(resync), .frame_size_o(fsize), .irq_o(irq));
    task automatic conclude();
        if (q.size() != 0) begin
            fail_count++;
            $display("ERROR %0t: %0d reads never answered", $time, q.size());
        end
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %0t: saw %h want %h", $time, s, e);
        end
    endtask
    // entered just after an edge; ends one edge after release
    task automatic bus(input logic w, input logic [10:0] a,
                       input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {a, 2'b00};
        wdat <= {24'h0, d};
        // no limit of its own: the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [10:0] a, input logic [7:0] e);
        q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic pulse(input logic [7:0] m, input int n);
        repeat (n) begin
            want[7:0] <= m;
            @(posedge clk_i);
            want[7:0] <= 8'h00;
            @(posedge clk_i);
        end
        repeat (4) @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
            chk(rdat[7:0], q.pop_front());
        end
    end
    initial begin
        repeat (4000) @(posedge clk_i);
        fail_count++;
        conclude();
    end
    initial begin
        logic [7:0] pat, me, nb;
        int ln;
        {cyc, stb, we, adr, wdat} = '0;
        sel = 4'hF;
        rst_i = 1'b1;
        want = {32'hFFFF_FFFF, 8'h00};
        void'($urandom(32'h678C));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b1, IDX_IRQ_VECTOR, 8'hFF);
        rd(IDX_FRAME_SIZE, 8'h01);
        bus(1'b1, IDX_FRAME_SIZE, 8'h04);
        rd(IDX_FRAME_SIZE, 8'h04);
        chk(fsize, 8'h04);
        // a write without byte lane 0 must leave the register alone
        sel <= 4'hE;
        bus(1'b1, IDX_FRAME_SIZE, 8'h02);
        sel <= 4'hF;
        rd(IDX_FRAME_SIZE, 8'h04);
        bus(1'b1, IDX_FRAME_SIZE, 8'h02);
        rd(IDX_FRAME_SIZE, 8'h02);
        chk(fsize, 8'h02);
        rd(11'h000, 8'h00);
        ln = $urandom_range(7);
        me = 8'h01 << ln;
        nb = 8'h01 << ((ln + 1) % 8);
        for (int k = 0; k < 4; k++) begin
            pat = 8'($urandom) & ~me;
            want[8+8*k +: 8] <= pat;
            repeat (5) @(posedge clk_i);
            rd(IDX_CODE_GROUP + 11'(k), pat);
            if (k == 0 || k == 3) chk({7'h0, sync_a}, 8'h01);
            want[8+8*k +: 8] <= 8'hFF;
        end
        repeat (5) @(posedge clk_i);
        chk({7'h0, sync_a}, 8'h00);
        rd(IDX_IRQ_VECTOR, 8'h0F);
        bus(1'b1, IDX_IRQ_MASK, 8'h2F);
        repeat (3) @(posedge clk_i);
        chk({7'h0, irq}, 8'h01);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, IDX_CODE_GROUP + 11'(k), 8'h80);
            rd(IDX_IRQ_VECTOR, 8'h0F & (8'h0E << k));
        end
        chk({7'h0, irq}, 8'h00);
        bus(1'b1, IDX_LIMIT, 8'h03);
        pulse(me, 2);
        rd(IDX_STRAY_CHAR, 8'h00);
        pulse(me, 1);
        rd(IDX_STRAY_CHAR, me);
        rd(IDX_IRQ_VECTOR, 8'h20);
        chk({7'h0, irq}, 8'h01);
        bus(1'b1, IDX_STRAY_CHAR, 8'h80 | 8'((ln + 1) % 8));
        rd(IDX_IRQ_VECTOR, 8'h20);
        bus(1'b1, IDX_STRAY_CHAR, 8'h80 | 8'(ln));
        rd(IDX_IRQ_VECTOR, 8'h00);
        rd(IDX_STRAY_CHAR, me);
        chk({7'h0, irq}, 8'h00);
        bus(1'b1, IDX_STRAY_CHAR, 8'h20 | 8'(ln));
        rd(IDX_STRAY_CHAR, 8'h00);
        bus(1'b1, IDX_STRAY_CHAR, 8'h40 | 8'(ln));
        pulse(me | nb, 3);
        rd(IDX_STRAY_CHAR, nb);
        bus(1'b1, IDX_STRAY_CHAR, 8'h20 | 8'(ln));
        pulse(me, 3);
        rd(IDX_STRAY_CHAR, me | nb);
        conclude();
    end
endmodule // tb
`default_nettype wire
